// >>> srs_map.svh
// srs_map.svh: constants for the segment register select block
// assumes inclusion by srs_pkg, srs_select and the bench; srs_offset does not include it
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH
// segment register codes
`define SRS_SEG_EXTRA 2'h0
`define SRS_SEG_CODE 2'h1
`define SRS_SEG_STACK 2'h2
`define SRS_SEG_DATA 2'h3
// reference kinds
`define SRS_REF_FETCH 3'h0
`define SRS_REF_STACK 3'h1
`define SRS_REF_DATA 3'h2
`define SRS_REF_STR_DST 3'h3
`define SRS_REF_ALT_DATA 3'h4
// reset values
`define SRS_SEL_RESET 16'h0000
`define SRS_CODE_RESET 16'hffff
`endif

// >>> srs_pkg.sv
// srs_pkg.sv: types shared by the segment register select block
// assumes srs_map.svh is compiled alongside
`include "srs_map.svh"
package srs_pkg;
   typedef logic [1:0] srs_seg_t;
   typedef logic [2:0] srs_ref_t;
   // one memory reference request from the execution unit
   typedef struct packed
   {
      srs_ref_t kind;
      logic bp_base;
      logic ovr_valid;
      srs_seg_t ovr_seg;
      logic use_base;
      logic [15:0] base;
      logic use_index;
      logic [15:0] index;
      logic disp_wide;
      logic [15:0] disp;
   } srs_req_t;
   // two part pointer sent to translation
   typedef struct packed
   {
      srs_seg_t seg;
      logic [15:0] selector;
      logic [15:0] offset;
   } srs_ptr_t;
endpackage : srs_pkg

// >>> srs_offset.sv
// srs_offset.sv: combinational offset adder for memory references
// assumes operands arrive already registered in the caller's domain
`timescale 1ns/1ps
`default_nettype none
module srs_offset
   import srs_pkg::*;
(
   // operands
   input wire logic i_use_base,
   input wire logic [15:0] i_base,
   input wire logic i_use_index,
   input wire logic [15:0] i_index,
   input wire logic i_disp_wide,
   input wire logic [15:0] i_disp,
   // result
   output logic [15:0] o_offset
);
   // ==========================================
   // sign extension
   function automatic logic [15:0] srs_sext8(input logic [7:0] b);
      srs_sext8 = {{8{b[7]}}, b};
   endfunction : srs_sext8

   logic [15:0] disp_ext;
   always_comb
   begin
      disp_ext = i_disp_wide ? i_disp : srs_sext8(i_disp[7:0]);
   end

   // ==========================================
   // wrapping sum
   always_comb
   begin
      o_offset = disp_ext
         + (i_use_base ? i_base : 16'h0000)
         + (i_use_index ? i_index : 16'h0000); // carry dropped
   end
endmodule : srs_offset
`default_nettype wire

// >>> srs_select.sv
// srs_select.sv: segment register select and two part pointer former
// assumes requests come from logic on i_clk; loads come from the execution unit
//
// Operation
// - each segment is a contiguous byte range of at most 64K, addressed from offset zero.
// - memory is addressed by a 16-bit selector plus a 16-bit offset.
// - every operand access carries both a segment from a register and an offset.
// - instruction prefetch always uses the code segment.
// - stack pushes, pops and base-pointer-based references default to the stack segment.
// - other data references default to data_segment_reg.
// - string destinations and alternate data use extra_segment_reg.
// - an override prefix replaces the implicit segment for that access.
// - stack, data and extra registers may hold the same selector with no fault.
// - carry out of the 16-bit offset sum is discarded.
// - 8-bit displacements are sign extended before the sum.
`timescale 1ns/1ps
`default_nettype none
`include "srs_map.svh"
module srs_select
   import srs_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // segment register load
   input wire logic i_load,
   input wire srs_seg_t i_load_seg,
   input wire logic [15:0] i_load_sel,
   // request
   input wire logic i_req,
   input wire srs_req_t i_req_data,
   // pointer out
   output logic o_valid,
   output srs_ptr_t o_ptr
);
   // ==========================================
   // segment registers
   logic [15:0] seg_regs [4];

   // no comparison among registers, overlap is legal
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         seg_regs[0] <= `SRS_SEL_RESET;
         seg_regs[1] <= `SRS_CODE_RESET;
         seg_regs[2] <= `SRS_SEL_RESET;
         seg_regs[3] <= `SRS_SEL_RESET;
      end
      else if (i_load)
      begin
         seg_regs[i_load_seg] <= i_load_sel;
      end
   end

   // ==========================================
   // implicit selection
   function automatic srs_seg_t srs_pick(input srs_req_t r);
      if (r.kind == `SRS_REF_FETCH)
         srs_pick = `SRS_SEG_CODE;
      else if (r.ovr_valid)
         srs_pick = r.ovr_seg;
      else
      begin
         case (r.kind)
            `SRS_REF_STACK: srs_pick = `SRS_SEG_STACK;
            `SRS_REF_STR_DST: srs_pick = `SRS_SEG_EXTRA;
            `SRS_REF_ALT_DATA: srs_pick = `SRS_SEG_EXTRA;
            default: srs_pick = r.bp_base ? `SRS_SEG_STACK : `SRS_SEG_DATA;
         endcase
      end
   endfunction : srs_pick

   srs_seg_t next_seg;
   logic [15:0] next_offset;
   always_comb
   begin
      next_seg = srs_pick(i_req_data);
   end

   srs_offset u_offset (
      .i_use_base(i_req_data.use_base),
      .i_base(i_req_data.base),
      .i_use_index(i_req_data.use_index),
      .i_index(i_req_data.index),
      .i_disp_wide(i_req_data.disp_wide),
      .i_disp(i_req_data.disp),
      .o_offset(next_offset)
   );

   // ==========================================
   // registered pointer
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_valid <= 1'b0;
      else
         o_valid <= i_req;
   end

   // offset width caps each segment at 64K bytes
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_ptr <= '0;
      else if (i_req)
      begin
         o_ptr.seg <= next_seg;
         o_ptr.selector <= seg_regs[next_seg];
         o_ptr.offset <= next_offset;
      end
   end

   // ==========================================
   // checks
   AST_FETCH_CODE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && i_req_data.kind == `SRS_REF_FETCH |=> o_valid && o_ptr.seg == `SRS_SEG_CODE)
      else $error("fetch not on code segment");
   AST_OVERRIDE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && i_req_data.kind != `SRS_REF_FETCH && i_req_data.ovr_valid
      |=> o_ptr.seg == $past(i_req_data.ovr_seg))
      else $error("override ignored");
   AST_STACK: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && !i_req_data.ovr_valid && i_req_data.kind == `SRS_REF_STACK
      |=> o_ptr.seg == `SRS_SEG_STACK)
      else $error("stack ref not on stack segment");
   AST_BP_STACK: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && !i_req_data.ovr_valid && i_req_data.kind == `SRS_REF_DATA && i_req_data.bp_base
      |=> o_ptr.seg == `SRS_SEG_STACK)
      else $error("base pointer ref not on stack segment");
   AST_DATA: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && !i_req_data.ovr_valid && i_req_data.kind == `SRS_REF_DATA && !i_req_data.bp_base
      |=> o_ptr.seg == `SRS_SEG_DATA)
      else $error("data ref not on data segment");
   AST_STRDST: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && !i_req_data.ovr_valid && i_req_data.kind == `SRS_REF_STR_DST
      |=> o_ptr.seg == `SRS_SEG_EXTRA)
      else $error("string destination not on extra segment");
   AST_SELECTOR: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && !i_load |=> o_ptr.selector == seg_regs[o_ptr.seg])
      else $error("selector does not match register");
   AST_VALID: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req |=> o_valid)
      else $error("request lost");
   AST_WRAP: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && i_req_data.use_base && !i_req_data.use_index && i_req_data.disp_wide
      |=> o_ptr.offset == 16'($past(i_req_data.base) + $past(i_req_data.disp)))
      else $error("offset sum wrong");
   AST_SEXT: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && !i_req_data.use_base && !i_req_data.use_index && !i_req_data.disp_wide
      |=> o_ptr.offset == {{8{$past(i_req_data.disp[7])}}, $past(i_req_data.disp[7:0])})
      else $error("displacement not sign extended");
   AST_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_load |=> seg_regs[$past(i_load_seg)] == $past(i_load_sel))
      else $error("segment load lost");

   AST_KEEP_CODE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_load && i_load_seg != `SRS_SEG_CODE |=> $stable(seg_regs[`SRS_SEG_CODE]))
      else $error("code register disturbed by another load");

   // ==========================================
   // selection checks beyond the basic table
   AST_ALT_DATA: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && !i_req_data.ovr_valid && i_req_data.kind == `SRS_REF_ALT_DATA
      |=> o_ptr.seg == `SRS_SEG_EXTRA)
      else $error("alternate data not on extra segment");

   AST_STR_NO_BP: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && !i_req_data.ovr_valid && i_req_data.bp_base
      && (i_req_data.kind == `SRS_REF_STR_DST || i_req_data.kind == `SRS_REF_ALT_DATA)
      |=> o_ptr.seg == `SRS_SEG_EXTRA)
      else $error("base pointer flag moved extra segment reference");

   AST_FETCH_NO_OVR: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && i_req_data.kind == `SRS_REF_FETCH && i_req_data.ovr_valid
      |=> o_ptr.selector == $past(seg_regs[`SRS_SEG_CODE]))
      else $error("fetch followed an override");

   AST_OVR_SELECTOR: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && !i_load && i_req_data.kind != `SRS_REF_FETCH && i_req_data.ovr_valid
      |=> o_ptr.selector == seg_regs[$past(i_req_data.ovr_seg)])
      else $error("override selector wrong");

   AST_LOAD_OLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && i_load && i_load_seg == next_seg && i_load_sel != seg_regs[next_seg]
      |=> o_ptr.selector != seg_regs[o_ptr.seg])
      else $error("request saw the same cycle load");

   // ==========================================
   // output timing checks
   AST_PULSE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !i_req |=> !o_valid)
      else $error("valid without request");

   AST_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !i_req |=> $stable(o_ptr))
      else $error("pointer changed without request");

   // ==========================================
   // offset checks
   AST_ZERO_BASE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && !i_req_data.use_base && !i_req_data.use_index && i_req_data.disp == 16'h0000
      |=> o_ptr.offset == 16'h0000)
      else $error("empty offset not zero");

   AST_FULL_SUM: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && i_req_data.use_base && i_req_data.use_index && i_req_data.disp_wide
      |=> o_ptr.offset
         == 16'($past(i_req_data.base) + $past(i_req_data.index) + $past(i_req_data.disp)))
      else $error("three part offset sum wrong");

   // ==========================================
   // scenario covers
   COV_FETCH: cover property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && i_req_data.kind == `SRS_REF_FETCH);
   COV_OVR: cover property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && i_req_data.ovr_valid && i_req_data.kind == `SRS_REF_DATA);
   COV_BP: cover property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && i_req_data.bp_base && !i_req_data.ovr_valid);
   COV_WRAP: cover property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && i_req_data.use_base && (17'(i_req_data.base) + 17'(i_req_data.disp)) > 17'h0ffff);
   COV_LOAD_REQ: cover property (@(posedge i_clk) disable iff (!i_rstn)
      i_req && i_load && i_load_seg == next_seg);
endmodule : srs_select
`default_nettype wire

// >>> srs_exec_model.sv
// srs_exec_model.sv: execution unit model issuing references
// assumes the bench calls send from its main sequence
`timescale 1ns/1ps
`default_nettype none
module srs_exec_model
   import srs_pkg::*;
(
   // clock
   input wire logic i_clk,
   // request out
   output logic o_req,
   output srs_req_t o_req_data
);
   initial
   begin
      o_req = 1'b0;
      o_req_data = '0;
   end
   // one reference per call; fields scrambled once released
   task automatic send(input srs_req_t r);
      @(posedge i_clk);
      o_req <= 1'b1;
      o_req_data <= r;
      @(posedge i_clk);
      o_req <= 1'b0;
      o_req_data <= ~r;
   endtask : send
endmodule : srs_exec_model
`default_nettype wire

// >>> tb_top.sv
// tb_top.sv: self-checking bench for segment register select
// assumes srs_pkg, srs_select and srs_exec_model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "srs_map.svh"
module tb_top;
   import srs_pkg::*;
   logic i_clk;
   logic i_rstn;
   logic i_load;
   logic i_req;
   logic o_valid;
   srs_seg_t i_load_seg;
   logic [15:0] i_load_sel;
   srs_req_t i_req_data;
   srs_ptr_t o_ptr;
   logic [15:0] sel [4];
   int err_total;
   int cmp_count;
   int cyc;
   srs_select u_srs_select (.i_clk(i_clk), .i_rstn(i_rstn), .i_load(i_load),
      .i_load_seg(i_load_seg), .i_load_sel(i_load_sel), .i_req(i_req),
      .i_req_data(i_req_data), .o_valid(o_valid), .o_ptr(o_ptr));
   srs_exec_model u_srs_exec_model (.i_clk(i_clk), .o_req(i_req), .o_req_data(i_req_data));
   // ==========
   // clock and hang limit
   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("mismatches %0d checks %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   // ==========
   // shared tasks
   task automatic load(input srs_seg_t s, input logic [15:0] v);
      @(posedge i_clk);
      i_load <= 1'b1;
      i_load_seg <= s;
      i_load_sel <= v;
      @(posedge i_clk);
      i_load <= 1'b0;
      sel[s] = v;
   endtask : load
   function automatic srs_req_t rq(input srs_ref_t k, input logic bp, input logic ov,
      input srs_seg_t os);
      rq = '0;
      rq.kind = k;
      rq.bp_base = bp;
      rq.ovr_valid = ov;
      rq.ovr_seg = os;
   endfunction : rq
   task automatic ref_chk(input srs_req_t r, input srs_seg_t s, input logic [15:0] off);
      srs_ptr_t e;
      e = {s, sel[s], off};
      u_srs_exec_model.send(r);
      #1;
      cmp_count++;
      if (o_valid !== 1'b1 || o_ptr !== e)
      begin
         err_total++;
         $display("CHECK FAILED o_ptr expected %h seen %h v=%b", e, o_ptr, o_valid);
      end
   endtask : ref_chk
   // ==========
   // scenarios
   task automatic t_reset();
      ref_chk(rq(`SRS_REF_FETCH, 1'b0, 1'b1, 2'h3), `SRS_SEG_CODE, 16'h0000);
      @(posedge i_clk);
      #1;
      cmp_count++;
      if (o_valid !== 1'b0)
      begin
         err_total++;
         $display("CHECK FAILED o_valid expected 0 seen %b", o_valid);
      end
   endtask : t_reset
   task automatic t_kinds();
      srs_seg_t ex [5] = '{`SRS_SEG_CODE, `SRS_SEG_STACK, `SRS_SEG_DATA, `SRS_SEG_EXTRA,
         `SRS_SEG_EXTRA};
      for (int i = 0; i < 4; i++)
         load(srs_seg_t'(i), 16'(16'h1111 * (i + 1)));
      for (int k = 0; k < 5; k++)
         ref_chk(rq(srs_ref_t'(k), 1'b0, 1'b0, 2'h0), ex[k], 16'h0000);
      ref_chk(rq(`SRS_REF_DATA, 1'b1, 1'b0, 2'h0), `SRS_SEG_STACK, 16'h0000);
      ref_chk(rq(`SRS_REF_STR_DST, 1'b1, 1'b0, 2'h0), `SRS_SEG_EXTRA, 16'h0000);
      for (int o = 0; o < 4; o++)
         ref_chk(rq(`SRS_REF_DATA, 1'b1, 1'b1, 2'(o)), 2'(o), 16'h0000);
   endtask : t_kinds
   task automatic t_offset();
      srs_req_t r;
      r = rq(`SRS_REF_DATA, 1'b0, 1'b0, 2'h0);
      r.use_base = 1'b1;
      r.base = 16'h0020;
      r.disp = 16'h12f0;
      ref_chk(r, `SRS_SEG_DATA, 16'h0010);
      r.use_index = 1'b1;
      r.index = 16'h8001;
      r.base = 16'h8000;
      r.disp_wide = 1'b1;
      r.disp = 16'hffff;
      ref_chk(r, `SRS_SEG_DATA, 16'h0000);
   endtask : t_offset
   task automatic t_overlap();
      for (int i = 0; i < 4; i++)
         if (i != 1)
            load(srs_seg_t'(i), 16'h5a5a);
      ref_chk(rq(`SRS_REF_STACK, 1'b0, 1'b0, 2'h0), `SRS_SEG_STACK, 16'h0000);
      ref_chk(rq(`SRS_REF_ALT_DATA, 1'b0, 1'b0, 2'h0), `SRS_SEG_EXTRA, 16'h0000);
   endtask : t_overlap
   task automatic t_midreset();
      fork
         load(`SRS_SEG_DATA, 16'h0c3c);
         ref_chk(rq(`SRS_REF_DATA, 1'b0, 1'b0, 2'h0), `SRS_SEG_DATA, 16'h0000);
      join
      ref_chk(rq(`SRS_REF_DATA, 1'b0, 1'b0, 2'h0), `SRS_SEG_DATA, 16'h0000);
      @(posedge i_clk);
      i_rstn <= 1'b0;
      @(posedge i_clk);
      #1;
      cmp_count++;
      if (o_valid !== 1'b0 || o_ptr !== '0)
      begin
         err_total++;
         $display("CHECK FAILED reset o_ptr expected 0 seen %h v=%b", o_ptr, o_valid);
      end
      sel = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
      sel[`SRS_SEG_CODE] = `SRS_CODE_RESET;
      @(posedge i_clk);
      i_rstn <= 1'b1;
      ref_chk(rq(`SRS_REF_DATA, 1'b0, 1'b0, 2'h0), `SRS_SEG_DATA, 16'h0000);
      ref_chk(rq(`SRS_REF_FETCH, 1'b0, 1'b0, 2'h0), `SRS_SEG_CODE, 16'h0000);
   endtask : t_midreset
   initial
   begin
      i_rstn = 1'b0;
      i_load = 1'b0;
      i_load_seg = 2'h0;
      i_load_sel = 16'h0000;
      sel = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
      sel[`SRS_SEG_CODE] = `SRS_CODE_RESET;
      repeat (5) @(posedge i_clk);
      i_rstn <= 1'b1;
      t_reset();
      t_kinds();
      t_offset();
      t_overlap();
      t_midreset();
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
